// ==== lsw_top.sv ====
// Limit switch output block: 64 settings, two regions each, 64 output points
// Function
// - Output ON while watch inside ON region
// - Up to two regions per setting
// - Signed two's-complement comparisons
// - Lower below upper: lower <= watch < upper
// - Lower above upper: region wraps around
// - Equal limits give OFF everywhere
// - Evaluate only while ready-complete is set
// - Without keep option, ready fall clears all
// - With keep option, non-relay points hold
// - Output relay points always clear on fall
// - Word-device limits captured at ready rise
// - Word-device limits reloaded every operation cycle
// - 64 settings, shared watch and targets
// - Targets receive OR of all region results
// - Enabled forced-off drives point OFF
// - Enabled forced-on drives ON, beats off
// - Single writes, or 16-point batch words
// - Up to four batch groups
// - Unassigned batch bits written OFF
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "lsw_defs.svh"
module lsw_top
  import lsw_pkg::*;
#(
  // Clock cycles per motion operation cycle
  parameter int OP_CYCLES = (`LSW_OPCYC_US * 1000) / `LSW_CLK_NS
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_B,
  // Register port
  input  wire logic [11:0]      ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  // Sequence CPU side
  input  wire logic             PLC_READY_FLAG,
  input  wire logic [3:0][31:0] WATCH,
  input  wire logic [7:0][31:0] WORD_DEV,
  input  wire logic [63:0]      FORCE_OFF,
  input  wire logic [63:0]      FORCE_ON,
  // Results
  output logic                  READY_COMPLETE_FLAG,
  output logic      [63:0]      OUT_POINT
);

  // Expands four group enables into a 64-point mask
  function automatic logic [63:0] grp_mask(input logic [3:0] b);
    grp_mask = {{16{b[3]}}, {16{b[2]}}, {16{b[1]}}, {16{b[0]}}};
  endfunction : grp_mask

  // Software state
  logic [7:0]  ctrl_reg;    // Keep option and batch group enables
  logic [7:0]  ctrl_next;
  logic [63:0] relay_reg;   // Points that are output relays
  logic [63:0] relay_next;
  logic [31:0] rdata_reg;   // Register read data
  logic [31:0] rdata_next;
  logic        rsel_reg;    // Read in the previous cycle went to the setting memory
  logic        rsel_next;

  // Operation cycle divider
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic        tick;

  // Ready tracking, outputs and scan sequencer
  logic        rdy_q_reg;   // Ready flag one cycle ago
  logic        rc_reg;      // Ready-complete state
  logic        rc_next;
  logic [63:0] out_reg;     // Output points
  logic [63:0] out_next;
  lsw_state_t  st_reg;
  lsw_state_t  st_next;
  logic [5:0]  idx_reg;     // Setting under scan
  logic [5:0]  idx_next;
  logic [2:0]  fld_reg;     // Word within the setting
  logic [2:0]  fld_next;
  logic [31:0] cfg_reg;     // Setting configuration word
  logic [31:0] cfg_next;
  logic [31:0] lo1_reg;     // Region 1 lower limit
  logic [31:0] lo1_next;
  logic [31:0] up1_reg;     // Region 1 upper limit
  logic [31:0] up1_next;
  logic [31:0] lo2_reg;     // Region 2 lower limit
  logic [31:0] lo2_next;
  logic [63:0] acc_reg;     // OR of region results per point
  logic [63:0] acc_next;
  logic [63:0] tch_reg;     // Points named by a valid setting
  logic [63:0] tch_next;
  logic [63:0] fon_reg;     // Forced-on points
  logic [63:0] fon_next;
  logic [63:0] foff_reg;    // Forced-off points
  logic [63:0] foff_next;

  // Shared combinational terms
  logic        rise;        // Ready flag rose
  logic        fall;        // Ready flag fell
  logic        mem_bus_rd;  // Bus read of the setting memory
  logic        mem_wr;      // Bus write of the setting memory
  logic [8:0]  mem_raddr;
  logic [31:0] mem_rdata;
  logic [31:0] cur_lim;     // Limit word chosen for this field
  logic [31:0] wv;          // Selected watch value
  logic        h1;          // Region 1 raw result
  logic        h2;          // Region 2 raw result
  logic        hit;         // Setting result
  logic [63:0] bmask;       // Batch group mask
  logic [63:0] keep_view;   // Non-relay part of the outputs
  int          k;           // Limit number 0..3

  assign rise       = ~rdy_q_reg & PLC_READY_FLAG;
  assign fall       = rdy_q_reg & ~PLC_READY_FLAG;
  assign mem_bus_rd = RD & ADDR[`LSW_MEM_BIT];
  assign mem_wr     = WR & ADDR[`LSW_MEM_BIT];
  assign mem_raddr  = mem_bus_rd ? ADDR[10:2] : {idx_reg, fld_reg};
  assign wv         = WATCH[cfg_reg[`LSW_F_WSEL +: 2]];
  assign bmask      = grp_mask(ctrl_reg[`LSW_C_BATCH +: 4]);
  assign keep_view  = out_reg & ~relay_reg;

  // Memory read data in the cycle after a memory read
  assign RDATA               = rsel_reg ? mem_rdata : rdata_reg;
  assign READY_COMPLETE_FLAG = rc_reg;
  assign OUT_POINT           = out_reg;

  // Setting memory, bus reads take the read port before the scan
  lsw_mem u_mem (
    .clk     (CLK),
    .wr_en   (mem_wr),
    .wr_addr (ADDR[10:2]),
    .wr_data (WDATA),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // Region 1 compare on held limits
  lsw_cmp u_cmp1 (
    .lo   (lo1_reg),
    .up   (up1_reg),
    .val  (wv),
    .wide (cfg_reg[`LSW_F_WIDE]),
    .hit  (h1)
  );

  // Region 2 compare, upper limit arrives as the last word
  lsw_cmp u_cmp2 (
    .lo   (lo2_reg),
    .up   (cur_lim),
    .val  (wv),
    .wide (cfg_reg[`LSW_F_WIDE]),
    .hit  (h2)
  );

  // Register writes and read decode
  always_comb begin
    ctrl_next  = ctrl_reg;
    relay_next = relay_reg;
    rdata_next = 32'h0000_0000;
    rsel_next  = mem_bus_rd;
    if (WR && !ADDR[`LSW_MEM_BIT]) begin
      unique case (ADDR)
        `LSW_A_CTRL:   ctrl_next = WDATA[7:0];
        `LSW_A_RLY_LO: relay_next[31:0] = WDATA;
        `LSW_A_RLY_HI: relay_next[63:32] = WDATA;
        default:       ctrl_next = ctrl_reg;
      endcase
    end
    if (RD && !ADDR[`LSW_MEM_BIT]) begin
      unique case (ADDR)
        `LSW_A_CTRL:   rdata_next = {24'h00_0000, ctrl_reg};
        `LSW_A_STAT:   rdata_next = {29'h0000_0000, PLC_READY_FLAG,
                                     (st_reg != LSW_S_IDLE), rc_reg};
        `LSW_A_RLY_LO: rdata_next = relay_reg[31:0];
        `LSW_A_RLY_HI: rdata_next = relay_reg[63:32];
        `LSW_A_OUT_LO: rdata_next = out_reg[31:0];
        `LSW_A_OUT_HI: rdata_next = out_reg[63:32];
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl_reg  <= `LSW_CTRL_RST;
      relay_reg <= 64'h0;
      rdata_reg <= 32'h0000_0000;
      rsel_reg  <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      relay_reg <= relay_next;
      rdata_reg <= rdata_next;
      rsel_reg  <= rsel_next;
    end
  end

  // Operation cycle tick, one pulse per period
  always_comb begin
    tick     = (div_reg == 32'(OP_CYCLES - 1));
    div_next = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_next;
    end
  end

  // Ready tracking, scan sequencer and output update
  always_comb begin
    rc_next   = rc_reg;
    out_next  = out_reg;
    st_next   = st_reg;
    idx_next  = idx_reg;
    fld_next  = fld_reg;
    cfg_next  = cfg_reg;
    lo1_next  = lo1_reg;
    up1_next  = up1_reg;
    lo2_next  = lo2_reg;
    acc_next  = acc_reg;
    tch_next  = tch_reg;
    fon_next  = fon_reg;
    foff_next = foff_reg;
    hit       = 1'b0;
    k         = int'(fld_reg) - 1;
    // Limit from a word device or from the constant in memory
    if (fld_reg != 3'h0 && cfg_reg[`LSW_F_SRC + k]) begin
      cur_lim = WORD_DEV[cfg_reg[`LSW_F_IDX + 3 * k +: 3]];
    end else begin
      cur_lim = mem_rdata;
    end
    if (fall) begin
      // Ready dropped: abort any scan; clear all outputs, or only the relay points when keep is set
      rc_next  = 1'b0;
      st_next  = LSW_S_IDLE;
      out_next = ctrl_reg[`LSW_C_KEEP] ? keep_view
                                       : 64'h0;
    end else begin
      if (rise) begin
        rc_next = 1'b1;
      end
      unique case (st_reg)
        LSW_S_IDLE: begin
          // Ready rise captures at once, then one scan per tick
          if (rise || (tick && rc_reg)) begin
            st_next   = LSW_S_ISSUE;
            idx_next  = 6'h00;
            fld_next  = 3'h0;
            acc_next  = 64'h0;
            tch_next  = 64'h0;
            fon_next  = 64'h0;
            foff_next = 64'h0;
          end
        end
        LSW_S_ISSUE: begin
          // Read waits while a bus read holds the port
          if (!mem_bus_rd) begin
            st_next = LSW_S_WAIT;
          end
        end
        LSW_S_WAIT: begin
          st_next  = LSW_S_ISSUE;
          fld_next = fld_reg + 3'h1;
          unique case (fld_reg)
            3'h0: begin
              cfg_next = mem_rdata;
              // Unused setting is skipped
              if (!mem_rdata[`LSW_F_VALID]) begin
                fld_next = `LSW_LAST_FLD;
              end
            end
            3'h1: lo1_next = cur_lim;
            3'h2: up1_next = cur_lim;
            3'h3: lo2_next = cur_lim;
            default: begin
              // Both regions ORed into the named point
              hit = (cfg_reg[`LSW_F_USE1] & h1) |
                    (cfg_reg[`LSW_F_USE2] & h2);
              acc_next[cfg_reg[5:0]] = acc_reg[cfg_reg[5:0]] | hit;
              tch_next[cfg_reg[5:0]] = 1'b1;
              if (cfg_reg[`LSW_F_FOFF] && FORCE_OFF[idx_reg]) begin
                foff_next[cfg_reg[5:0]] = 1'b1;
              end
              if (cfg_reg[`LSW_F_FON] && FORCE_ON[idx_reg]) begin
                fon_next[cfg_reg[5:0]] = 1'b1;
              end
            end
          endcase
          // End of a setting
          if (fld_reg == `LSW_LAST_FLD ||
              (fld_reg == 3'h0 && !mem_rdata[`LSW_F_VALID])) begin
            fld_next = 3'h0;
            idx_next = idx_reg + 6'h01;
            if (idx_reg == `LSW_LAST_SET) begin
              st_next = LSW_S_DONE;
            end
          end
        end
        LSW_S_DONE: begin
          st_next = LSW_S_IDLE;
          // Batch groups write whole words, other points only when named
          if (rc_reg) begin
            out_next = ((fon_reg | (acc_reg & ~foff_reg))
                        & (bmask | tch_reg))
                       | (out_reg & ~bmask & ~tch_reg);
          end
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdy_q_reg <= 1'b0;
      rc_reg    <= 1'b0;
      out_reg   <= 64'h0;
      st_reg    <= LSW_S_IDLE;
      idx_reg   <= 6'h00;
      fld_reg   <= 3'h0;
      cfg_reg   <= 32'h0000_0000;
      lo1_reg   <= 32'h0000_0000;
      up1_reg   <= 32'h0000_0000;
      lo2_reg   <= 32'h0000_0000;
      acc_reg   <= 64'h0;
      tch_reg   <= 64'h0;
      fon_reg   <= 64'h0;
      foff_reg  <= 64'h0;
    end else begin
      rdy_q_reg <= PLC_READY_FLAG;
      rc_reg    <= rc_next;
      out_reg   <= out_next;
      st_reg    <= st_next;
      idx_reg   <= idx_next;
      fld_reg   <= fld_next;
      cfg_reg   <= cfg_next;
      lo1_reg   <= lo1_next;
      up1_reg   <= up1_next;
      lo2_reg   <= lo2_next;
      acc_reg   <= acc_next;
      tch_reg   <= tch_next;
      fon_reg   <= fon_next;
      foff_reg  <= foff_next;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_fall_clears_all: assert property (
    fall && !ctrl_reg[`LSW_C_KEEP] |=> OUT_POINT == 64'h0 && !rc_reg)
    else $error("outputs not cleared on ready fall");

  a_keep_holds_pts: assert property (
    fall && ctrl_reg[`LSW_C_KEEP] && !WR |=> keep_view == $past(keep_view))
    else $error("kept outputs changed on ready fall");

  a_relay_clears: assert property (
    fall && !WR |=> (out_reg & relay_reg) == 64'h0)
    else $error("relay point still on after ready fall");

  a_idle_no_update: assert property (
    !rc_reg && !fall |=> $stable(out_reg))
    else $error("outputs moved outside ready-complete");

  a_only_at_done: assert property (
    st_reg != LSW_S_DONE && !fall |=> $stable(out_reg))
    else $error("outputs moved outside the update cycle");

  a_rise_capture: assert property (
    rise && st_reg == LSW_S_IDLE |=> st_reg == LSW_S_ISSUE && rc_reg)
    else $error("ready rise did not start a capture scan");

  a_tick_reload: assert property (
    tick && rc_reg && !fall && st_reg == LSW_S_IDLE |=> st_reg == LSW_S_ISSUE
    ##1 idx_reg == 6'h00)
    else $error("tick did not start a reload scan");

  a_force_on_wins: assert property (
    st_reg == LSW_S_DONE && rc_reg && !fall |=> (out_reg & fon_reg) == fon_reg)
    else $error("forced-on point not on");

  a_force_off_pt: assert property (
    st_reg == LSW_S_DONE && rc_reg && !fall
    |=> (out_reg & foff_reg & ~fon_reg) == 64'h0)
    else $error("forced-off point not off");

  a_batch_unused: assert property (
    st_reg == LSW_S_DONE && rc_reg && !fall
    |=> (out_reg & bmask & ~tch_reg) == 64'h0)
    else $error("unassigned batch bit not off");

  a_single_hold: assert property (
    st_reg == LSW_S_DONE && !fall && !WR
    |=> (out_reg & ~bmask & ~tch_reg) == $past(out_reg & ~bmask & ~tch_reg))
    else $error("unnamed single point was written");

  a_equal_off: assert property (
    st_reg == LSW_S_WAIT && fld_reg == `LSW_LAST_FLD && lo1_reg == up1_reg
    |-> !h1)
    else $error("equal limits gave ON");

  a_plain_region: assert property (
    st_reg == LSW_S_WAIT && cfg_reg[`LSW_F_WIDE]
    && $signed(lo1_reg) < $signed(up1_reg)
    |-> h1 == ($signed(wv) >= $signed(lo1_reg) && $signed(wv) < $signed(up1_reg)))
    else $error("ordered region result wrong");

  a_wrap_region: assert property (
    st_reg == LSW_S_WAIT && cfg_reg[`LSW_F_WIDE]
    && $signed(lo1_reg) > $signed(up1_reg)
    |-> h1 == ($signed(wv) >= $signed(lo1_reg) || $signed(wv) < $signed(up1_reg)))
    else $error("wrapped region result wrong");

endmodule : lsw_top

// ==== lsw_defs.svh ====
// Offsets, field positions, reset values and timing for the limit output block
`ifndef LSW_DEFS_SVH
`define LSW_DEFS_SVH
`define LSW_CLK_NS    20
`define LSW_OPCYC_US  888
`define LSW_A_CTRL    12'h000
`define LSW_A_STAT    12'h004
`define LSW_A_RLY_LO  12'h008
`define LSW_A_RLY_HI  12'h00c
`define LSW_A_OUT_LO  12'h010
`define LSW_A_OUT_HI  12'h014
`define LSW_MEM_BIT   11
`define LSW_CTRL_RST  8'h00
`define LSW_C_KEEP    0
`define LSW_C_BATCH   4
`define LSW_F_OUT     0
`define LSW_F_WSEL    6
`define LSW_F_WIDE    8
`define LSW_F_USE1    9
`define LSW_F_USE2    10
`define LSW_F_FOFF    11
`define LSW_F_FON     12
`define LSW_F_VALID   13
`define LSW_F_SRC     14
`define LSW_F_IDX     18
`define LSW_LAST_SET  6'h3f
`define LSW_LAST_FLD  3'h4
`endif

// ==== lsw_pkg.sv ====
// Types shared by the limit output block
package lsw_pkg;
  // Scan sequencer states
  typedef enum logic [1:0] {
    LSW_S_IDLE  = 2'b00,
    LSW_S_ISSUE = 2'b01,
    LSW_S_WAIT  = 2'b10,
    LSW_S_DONE  = 2'b11
  } lsw_state_t;
  // Signed limit or watch word
  typedef logic signed [31:0] lsw_word_t;
endpackage : lsw_pkg

// ==== lsw_mem.sv ====
// Setting memory: 64 settings of 8 words, one write and one registered read port
`timescale 1ns/1ns
module lsw_mem
  import lsw_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [8:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [8:0]  rd_addr,
  output logic      [31:0] rd_data
);
  // Storage array, contents undefined until software writes them
  logic [31:0] mem_reg [0:511];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule : lsw_mem

// ==== lsw_cmp.sv ====
// One ON region compare: signed lower/upper limits against the watch value
`timescale 1ns/1ns
module lsw_cmp
  import lsw_pkg::*;
(
  // Region limits and watch value
  input  wire logic [31:0] lo,
  input  wire logic [31:0] up,
  input  wire logic [31:0] val,
  // High for 32-bit data, low for 16-bit data in the low half
  input  wire logic        wide,
  // Region result
  output logic             hit
);
  // Sign extends 16-bit data, passes 32-bit data
  function automatic lsw_word_t ext(input logic [31:0] w, input logic wd);
    ext = wd ? w : {{16{w[15]}}, w[15:0]};
  endfunction : ext

  lsw_word_t lo_s;  // Signed lower limit
  lsw_word_t up_s;  // Signed upper limit
  lsw_word_t v_s;   // Signed watch value

  // Region decision by limit ordering
  always_comb begin
    lo_s = ext(lo, wide);
    up_s = ext(up, wide);
    v_s  = ext(val, wide);
    if (lo_s < up_s) begin
      hit = (v_s >= lo_s) && (v_s < up_s);
    end else if (lo_s > up_s) begin
      hit = (v_s >= lo_s) || (v_s < up_s);
    end else begin
      hit = 1'b0;
    end
  end
endmodule : lsw_cmp

// ==== lsw_cpu_model.sv ====
// Sequence CPU model: drives the ready flag and the word-device limit words
`timescale 1ns/1ns
module lsw_cpu_model
  import lsw_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Requests from the bench
  input  wire logic             want_ready,
  input  wire logic [7:0][31:0] dev_in,
  // Toward the block
  output logic                  plc_ready_flag,
  output logic      [7:0][31:0] word_dev
);
  // Everything changes just after an edge; the flag is low in reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      plc_ready_flag <= 1'b0;
    end else begin
      plc_ready_flag <= want_ready;
    end
    word_dev <= dev_in;
  end
endmodule : lsw_cpu_model

// ==== test_lsw_top.sv ====
// Self-checking bench for the limit output block
`timescale 1ns/1ns
`include "lsw_defs.svh"
module test_lsw_top
  import lsw_pkg::*;
;
  localparam int OPC = 800; // Shortened operation cycle
  // Bench side signals
  logic             clk;
  logic             rst_b;
  logic             wr;
  logic             rd;
  logic             want_ready;
  logic             plc_ready;
  logic             rc_flag;
  logic [11:0]      addr;
  logic [31:0]      wdata;
  logic [31:0]      rdata;
  logic [3:0][31:0] watch;
  logic [7:0][31:0] dev_in;
  logic [7:0][31:0] word_dev;
  logic [63:0]      f_off;
  logic [63:0]      f_on;
  logic [63:0]      out_point;
  int               error_cnt;
  int               n_checks;

  // Block under test
  lsw_top #(.OP_CYCLES(OPC)) dut (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PLC_READY_FLAG(plc_ready), .WATCH(watch), .WORD_DEV(word_dev),
    .FORCE_OFF(f_off), .FORCE_ON(f_on), .READY_COMPLETE_FLAG(rc_flag),
    .OUT_POINT(out_point));

  // Far-side model
  lsw_cpu_model cpu (
    .clk(clk), .rst_b(rst_b), .want_ready(want_ready), .dev_in(dev_in),
    .plc_ready_flag(plc_ready), .word_dev(word_dev));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // One-cycle write strobe
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bw

  // One-cycle read strobe; data stand in the following cycle only
  task automatic br(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Take the data at the edge that closes the cycle in which they stand
    @(posedge clk);
    d = rdata;
  endtask : br

  // Setting word: si holds {limit index, word source}
  function automatic logic [31:0] cfg(input logic [5:0] t, input logic [1:0] ws,
                                      input logic [5:0] fl, input logic [15:0] si = 16'h0);
    return {2'b00, si, fl, ws, t};
  endfunction : cfg

  // Write config and the four limit constants of one setting
  task automatic wset(input logic [5:0] s, input logic [31:0] c, input logic [31:0] l1,
                      input logic [31:0] u1, input logic [31:0] l2 = 32'h0,
                      input logic [31:0] u2 = 32'h0);
    logic [4:0][31:0] w;
    int               f;
    w = {u2, l2, u1, l1, c};
    for (f = 0; f < 5; f++) bw({1'b1, s, f[2:0], 2'b00}, w[f]);
  endtask : wset

  // Wait for a scan to start and end, bounded
  task automatic wait_scan;
    logic [31:0] s;
    bit          seen;
    int          i;
    seen = 1'b0;
    for (i = 0; i < 2000; i++) begin
      br(`LSW_A_STAT, s);
      if (s[1] === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (i == 2000) begin
      chk(64'h0, 64'h1, "scan timeout");
      finish_test();
    end
    repeat (2) @(posedge clk);
  endtask : wait_scan

  // Reset values, read-only and unmapped places
  task automatic t_reset;
    logic [31:0] d;
    br(`LSW_A_CTRL, d);
    chk(64'(d), 64'h0, "ctrl reset");
    br(`LSW_A_STAT, d);
    chk(64'(d), 64'h0, "status reset");
    br(`LSW_A_RLY_LO, d);
    chk(64'(d), 64'h0, "relay reset");
    bw(`LSW_A_OUT_LO, 32'hffffffff);
    br(`LSW_A_OUT_LO, d);
    chk(64'(d), 64'h0, "outputs read only");
    br(12'h018, d);
    chk(64'(d), 64'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  // Region compares, OR and forces after the ready rise
  task automatic t_compare;
    int i;
    for (i = 0; i < 64; i++) bw({1'b1, i[5:0], 5'h00}, 32'h0); // Invalidate every setting first
    wset(6'h00, cfg(6'h00, 2'h0, 6'h23), 32'h64, 32'hc8);
    wset(6'h01, cfg(6'h01, 2'h0, 6'h23), 32'h32, 32'h64);
    wset(6'h02, cfg(6'h02, 2'h0, 6'h23), 32'h96, 32'hfffffffb);
    wset(6'h03, cfg(6'h03, 2'h0, 6'h23), 32'h12c, 32'h65);
    wset(6'h04, cfg(6'h04, 2'h0, 6'h23), 32'h64, 32'h64);
    wset(6'h05, cfg(6'h05, 2'h1, 6'h22), 32'hfffffff6, 32'h0);
    wset(6'h06, cfg(6'h06, 2'h0, 6'h27), 32'h0, 32'ha, 32'h5a, 32'h6e);
    wset(6'h07, cfg(6'h06, 2'h0, 6'h23), 32'h0, 32'ha);
    wset(6'h08, cfg(6'h07, 2'h0, 6'h2b), 32'h0, 32'hc8);
    wset(6'h09, cfg(6'h08, 2'h0, 6'h3b), 32'h0, 32'ha);
    wset(6'h0a, cfg(6'h09, 2'h0, 6'h23), 32'h0, 32'hc8);
    wset(6'h0b, cfg(6'h0a, 2'h0, 6'h23, 16'h0083), 32'h0, 32'h0);
    wset(6'h0c, cfg(6'h10, 2'h0, 6'h23), 32'h0, 32'hc8);
    wset(6'h0d, cfg(6'h11, 2'h0, 6'h23), 32'h0, 32'hc8);
    repeat (OPC + 50) @(posedge clk);
    chk(out_point, 64'h0, "idle before ready");
    @(posedge clk);
    want_ready <= 1'b1;
    wait_scan();
    chk(64'(rc_flag), 64'h1, "ready complete");
    chk(out_point & 64'h3f, 64'h29, "regions");
    chk(out_point & 64'h40, 64'h40, "or of regions");
    chk(out_point & 64'h380, 64'h300, "forces");
    chk(out_point, 64'h30769, "all points");
    $display("test compare done");
  endtask : t_compare

  // Word-device limits reloaded each operation cycle
  task automatic t_reload;
    @(posedge clk);
    dev_in[1] <= 32'h5f;
    wait_scan();
    chk(out_point, 64'h30369, "word reload");
    $display("test reload done");
  endtask : t_reload

  // Single point writes, then 16-point batch words
  task automatic t_batch;
    bw({1'b1, 6'h0c, 5'h00}, 32'h0);
    wait_scan();
    chk(out_point, 64'h30369, "unnamed point holds");
    bw(`LSW_A_CTRL, 32'hf0);
    wait_scan();
    chk(out_point, 64'h20369, "batch clears unnamed");
    $display("test batch done");
  endtask : t_batch

  // Ready fall with and without the keep option
  task automatic t_fall;
    logic [31:0] d;
    @(posedge clk);
    want_ready <= 1'b0;
    repeat (3) @(posedge clk);
    chk(64'(rc_flag), 64'h0, "ready drop");
    chk(out_point, 64'h0, "clear on drop");
    bw(`LSW_A_RLY_LO, 32'h1);
    bw(`LSW_A_CTRL, 32'hf1);
    @(posedge clk);
    want_ready <= 1'b1;
    // Memory read while the rise scan runs falls in a wait cycle, so the scan does not stall
    repeat (4) @(posedge clk);
    br({1'b1, 6'h00, 5'h00}, d);
    chk(64'(d), 64'(cfg(6'h00, 2'h0, 6'h23)), "memory read in scan");
    wait_scan();
    chk(out_point, 64'h20369, "second rise");
    @(posedge clk);
    want_ready <= 1'b0;
    repeat (3) @(posedge clk);
    chk(out_point, 64'h20368, "keep but relay clears");
    $display("test fall done");
  endtask : t_fall

  // Main sequence
  initial begin
    error_cnt  = 0;
    n_checks   = 0;
    rst_b      = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 12'h0;
    wdata      = 32'h0;
    want_ready = 1'b0;
    watch      = '0;
    watch[0]   = 32'h64;
    watch[1]   = 32'h1234fffb;
    dev_in     = '0;
    dev_in[0]  = 32'h5a;
    dev_in[1]  = 32'h96;
    f_off      = 64'h700;
    f_on       = 64'h200;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_compare();
    t_reload();
    t_batch();
    t_fall();
    finish_test();
  end
endmodule : test_lsw_top
